//--- bdc_pkg.sv
// package of constants and types for the background debug command unit
package bdc_pkg;
  // command opcodes, 4 bits, an encoding of our own
  localparam logic [3:0] CMD_NOP     = 4'h0;
  localparam logic [3:0] CMD_RD_CORE = 4'h1;
  localparam logic [3:0] CMD_WR_CORE = 4'h2;
  localparam logic [3:0] CMD_RD_SYS  = 4'h3;
  localparam logic [3:0] CMD_WR_SYS  = 4'h4;
  localparam logic [3:0] CMD_RD_MEM  = 4'h5;
  localparam logic [3:0] CMD_WR_MEM  = 4'h6;
  localparam logic [3:0] CMD_DUMP    = 4'h7;
  localparam logic [3:0] CMD_FILL    = 4'h8;
  localparam logic [3:0] CMD_GO      = 4'h9;
  localparam logic [3:0] CMD_CALL    = 4'ha;
  localparam logic [3:0] CMD_RST     = 4'hb;
  // memory access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // answer status codes
  localparam logic [1:0] ST_OK       = 2'h0;
  localparam logic [1:0] ST_NOT_HALT = 2'h1;
  localparam logic [1:0] ST_ILLEGAL  = 2'h2;
  // system register selectors
  localparam logic [3:0] SYS_PC  = 4'h0;
  localparam logic [3:0] SYS_SR  = 4'h1;
  localparam logic [3:0] SYS_SRC_SPACE = 4'h2;
  localparam logic [3:0] SYS_DST_SPACE = 4'h3;
  localparam logic [3:0] SYS_USP = 4'h4;
  localparam logic [3:0] SYS_SSP = 4'h5;
  localparam logic [3:0] SYS_VBR = 4'h6;
  localparam logic [3:0] SYS_ATEMP = 4'h7;
  // reset values
  localparam logic [31:0] PC_RST  = 32'h0000_0000;
  localparam logic [15:0] SR_RST  = 16'h2700;
  localparam logic [31:0] SSP_RST = 32'h0000_1000;
  // peripheral reset pulse: 512 system clocks
  localparam int unsigned PRST_CYCLES = 512;
  localparam logic [9:0]  PRST_LAST   = 10'(PRST_CYCLES - 1);
  // command fifo shape: opcode 4 + sel 4 + size 2 + data 32
  localparam int unsigned CMD_W = 42;
  localparam int unsigned FIFO_D = 4;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_EXEC   = 9'h002,
    ST_MEMREQ = 9'h004,
    ST_MEMWT  = 9'h008,
    ST_PUSH   = 9'h010,
    ST_PUSHWT = 9'h020,
    ST_FLUSH  = 9'h040,
    ST_RSTP   = 9'h080,
    ST_ANS    = 9'h100
  } bdc_state_t;
endpackage : bdc_pkg

//--- bdc_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module bdc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input  wire logic         clk,     // system clock
  input  wire logic         rst_n,   // synchronised reset, low active
  input  wire logic [W-1:0] in_data, // write data
  input  wire logic         in_valid,// write request
  output logic              in_ready,// room left
  output logic [W-1:0]      out_data,// head word
  output logic              out_valid,// not empty
  input  wire logic         out_ready // head taken
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
    if (push)
      mem[wp_ff] <= in_data;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
      if (pop)
        rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
endmodule : bdc_fifo

//--- bdc_regfile.sv
// core register file: eight data and eight address registers
`timescale 1ns/1ps
module bdc_regfile (
  input  wire logic        clk,   // system clock
  input  wire logic        rst_n, // synchronised reset, low active
  input  wire logic [3:0]  rsel,  // read select, bit 3 picks address regs
  output logic [31:0]      rdata, // read data
  input  wire logic        we,    // write strobe
  input  wire logic [3:0]  wsel,  // write select
  input  wire logic [31:0] wdata  // write data
);
  logic [31:0] regs_ff [16];

  assign rdata = regs_ff[rsel];

  for (genvar i = 0; i < 16; i++)
  begin : g_reg
    always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
        regs_ff[i] <= 32'h0000_0000;
      else if (we && (wsel == 4'(i)))
        regs_ff[i] <= wdata;
  end
endmodule : bdc_regfile

//--- bdc_unit.sv
// background debug command unit: executes host commands on a halted core
// Overview of operation
// - read core register returns data or address register contents to host
// - write core register stores host operand in named data/address register
// - read system register returns named system control register value
// - every supervisor-readable system register is readable while halted
// - write system register loads host operand into named system register
// - memory read fetches sized data at long-word address and returns it
// - memory read address space comes from source space code register
// - memory write stores the address word itself at that supplied long-word address
// - memory write address space comes from destination space code register
// - block dump starts with memory read, then returns successive operands
// - block fill starts with memory write, then writes successive operands
// - resume flushes and refills pipeline, runs from current program counter
// - patch decrements stack pointer by 4, pushes program counter there
// - after stacking, execution starts at user patch code
// - peripheral reset drives external reset for exactly 512 clocks
// - peripheral reset leaves the core itself unreset
// - peripheral reset acts like the core's own reset instruction
// - null command changes no state
`timescale 1ns/1ps
module bdc_unit
  import bdc_pkg::*;
(
  input  wire logic        clk,          // 200 MHz system clock
  input  wire logic        rst_n,        // async reset, low active
  input  wire logic        cmd_valid,    // host command offered
  output logic             cmd_ready,    // fifo has room
  input  wire logic [3:0]  cmd_op,       // command opcode
  input  wire logic [3:0]  cmd_sel,      // register select
  input  wire logic [1:0]  cmd_size,     // memory access size
  input  wire logic [31:0] cmd_data,     // operand or address
  output logic             rsp_valid,    // answer pulse
  output logic [31:0]      rsp_data,     // answer data
  output logic [1:0]       rsp_status,   // answer status
  input  wire logic        core_halted,  // core in background mode (pin)
  input  wire logic [31:0] patch_addr,   // user patch code entry
  output logic             mem_req,      // memory cycle strobe
  output logic             mem_we,       // memory write
  output logic [31:0]      mem_addr,     // memory address
  output logic [2:0]       mem_fc,       // address space code
  output logic [1:0]       mem_size,     // access size
  output logic [31:0]      mem_wdata,    // write data
  input  wire logic        mem_ack,      // memory cycle done
  input  wire logic [31:0] mem_rdata,    // read data
  output logic             pipe_flush,   // flush pipeline pulse
  output logic             resume,       // leave background mode pulse
  output logic [31:0]      resume_pc,    // execution restart address
  output logic             periph_rst_n  // external reset line, low active
);
  typedef struct packed {
    bdc_state_t  st;
    logic [31:0] pc;
    logic [15:0] sr;
    logic [2:0]  source_space_code_reg;
    logic [2:0]  dest_space_code_reg;
    logic [31:0] usp;
    logic [31:0] ssp;
    logic [31:0] vbr;
    logic [31:0] atemp;
    logic [31:0] blk_addr;
    logic [1:0]  blk_size;
    logic        blk_ok;
    logic [9:0]  rcnt;
    logic        rsp_valid;
    logic [31:0] rsp_data;
    logic [1:0]  rsp_status;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [2:0]  mem_fc;
    logic [1:0]  mem_size;
    logic [31:0] mem_wdata;
    logic        pipe_flush;
    logic        resume;
    logic [31:0] resume_pc;
    logic        prst_n;
    logic [3:0]  op;
    logic [3:0]  sel;
  } bdc_regs_t;

  bdc_regs_t   cur_ff;
  bdc_regs_t   nxt_cur;
  logic [1:0]  rst_sync_ff;
  logic        srst_n;
  logic [1:0]  halt_sync_ff;
  logic        halted;
  logic [CMD_W-1:0] f_data;
  logic        f_valid;
  logic        f_ready;
  logic [3:0]  f_op;
  logic [3:0]  f_sel;
  logic [1:0]  f_size;
  logic [31:0] f_arg;
  logic [31:0] rf_rdata;
  logic        rf_we;
  logic [31:0] step;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  assign srst_n = rst_sync_ff[1];

  // halt level comes from the core's pin domain, two stages before use
  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
      halt_sync_ff <= 2'h0;
    else
      halt_sync_ff <= {halt_sync_ff[0], core_halted};
  assign halted = halt_sync_ff[1];

  bdc_fifo #(
    .W (CMD_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (srst_n),
    .in_data   ({cmd_op, cmd_sel, cmd_size, cmd_data}),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );
  assign {f_op, f_sel, f_size, f_arg} = f_data;
  // one command at a time; the fifo fills while a memory cycle stalls
  assign f_ready = (cur_ff.st == ST_IDLE);

  assign rf_we = (cur_ff.st == ST_IDLE) && f_valid && halted
                 && (f_op == CMD_WR_CORE);

  bdc_regfile u_rf (
    .clk   (clk),
    .rst_n (srst_n),
    .rsel  (f_sel),
    .rdata (rf_rdata),
    .we    (rf_we),
    .wsel  (f_sel),
    .wdata (f_arg)
  );

  always_comb
  begin
    unique case (cur_ff.blk_size)
      SZ_BYTE: step = 32'h0000_0001;
      SZ_WORD: step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
  end

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.rsp_valid  = 1'b0;
    nxt_cur.pipe_flush = 1'b0;
    nxt_cur.resume     = 1'b0;
    unique case (cur_ff.st)
      ST_IDLE:
      begin
        if (f_valid)
        begin
          nxt_cur.op  = f_op;
          nxt_cur.sel = f_sel;
          nxt_cur.rsp_status = ST_OK;
          nxt_cur.rsp_data   = 32'h0000_0000;
          nxt_cur.st  = ST_ANS;
          if (!halted)
            nxt_cur.rsp_status = ST_NOT_HALT;
          else
          begin
            unique case (f_op)
              CMD_NOP: ;
              CMD_RD_CORE: nxt_cur.rsp_data = rf_rdata;
              CMD_WR_CORE: ;
              CMD_RD_SYS:
                // all supervisor-visible registers are open here
                unique case (f_sel)
                  SYS_PC:    nxt_cur.rsp_data = cur_ff.pc;
                  SYS_SR:    nxt_cur.rsp_data = {16'h0000, cur_ff.sr};
                  SYS_SRC_SPACE:
                    nxt_cur.rsp_data = {29'h0, cur_ff.source_space_code_reg};
                  SYS_DST_SPACE:
                    nxt_cur.rsp_data = {29'h0, cur_ff.dest_space_code_reg};
                  SYS_USP:   nxt_cur.rsp_data = cur_ff.usp;
                  SYS_SSP:   nxt_cur.rsp_data = cur_ff.ssp;
                  SYS_VBR:   nxt_cur.rsp_data = cur_ff.vbr;
                  SYS_ATEMP: nxt_cur.rsp_data = cur_ff.atemp;
                  default:   nxt_cur.rsp_status = ST_ILLEGAL;
                endcase
              CMD_WR_SYS:
                unique case (f_sel)
                  SYS_PC:    nxt_cur.pc    = f_arg;
                  SYS_SR:    nxt_cur.sr    = f_arg[15:0];
                  SYS_SRC_SPACE:
                    nxt_cur.source_space_code_reg = f_arg[2:0];
                  SYS_DST_SPACE:
                    nxt_cur.dest_space_code_reg   = f_arg[2:0];
                  SYS_USP:   nxt_cur.usp   = f_arg;
                  SYS_SSP:   nxt_cur.ssp   = f_arg;
                  SYS_VBR:   nxt_cur.vbr   = f_arg;
                  SYS_ATEMP: nxt_cur.atemp = f_arg;
                  default:   nxt_cur.rsp_status = ST_ILLEGAL;
                endcase
              CMD_RD_MEM, CMD_WR_MEM:
              begin
                // start address is kept for later dump/fill
                nxt_cur.blk_addr = f_arg;
                nxt_cur.blk_size = (f_size == 2'h3) ? SZ_LONG : f_size;
                nxt_cur.blk_ok   = 1'b1;
                // one word carries the address, so a first write stores it
                nxt_cur.mem_wdata = f_arg;
                nxt_cur.st       = ST_MEMREQ;
              end
              CMD_DUMP, CMD_FILL:
                if (cur_ff.blk_ok)
                begin
                  // the fifo head moves on at the pop, so keep the operand
                  nxt_cur.mem_wdata = f_arg;
                  nxt_cur.st        = ST_MEMREQ;
                end
                else
                  nxt_cur.rsp_status = ST_ILLEGAL;
              CMD_GO:
              begin
                nxt_cur.pipe_flush = 1'b1;
                nxt_cur.st = ST_FLUSH;
              end
              CMD_CALL:
              begin
                nxt_cur.ssp = cur_ff.ssp - 32'h0000_0004;
                nxt_cur.st  = ST_PUSH;
              end
              CMD_RST:
              begin
                // core state untouched, only the pin pulses
                nxt_cur.prst_n = 1'b0;
                nxt_cur.rcnt   = 10'h000;
                nxt_cur.st     = ST_RSTP;
              end
              default: nxt_cur.rsp_status = ST_ILLEGAL;
            endcase
          end
        end
      end
      ST_MEMREQ:
      begin
        nxt_cur.mem_req  = 1'b1;
        nxt_cur.mem_addr = cur_ff.blk_addr;
        nxt_cur.mem_size = cur_ff.blk_size;
        if (cur_ff.op == CMD_RD_MEM || cur_ff.op == CMD_DUMP)
        begin
          nxt_cur.mem_we = 1'b0;
          nxt_cur.mem_fc = cur_ff.source_space_code_reg;
        end
        else
        begin
          nxt_cur.mem_we    = 1'b1;
          nxt_cur.mem_fc    = cur_ff.dest_space_code_reg;
        end
        nxt_cur.st = ST_MEMWT;
      end
      ST_MEMWT:
        if (mem_ack)
        begin
          nxt_cur.mem_req = 1'b0;
          if (!cur_ff.mem_we)
            nxt_cur.rsp_data = mem_rdata;
          nxt_cur.blk_addr = cur_ff.blk_addr + step;
          nxt_cur.st = ST_ANS;
        end
      ST_PUSH:
      begin
        nxt_cur.mem_req   = 1'b1;
        nxt_cur.mem_we    = 1'b1;
        nxt_cur.mem_addr  = cur_ff.ssp;
        nxt_cur.mem_fc    = cur_ff.dest_space_code_reg;
        nxt_cur.mem_size  = SZ_LONG;
        nxt_cur.mem_wdata = cur_ff.pc;
        nxt_cur.st = ST_PUSHWT;
      end
      ST_PUSHWT:
        if (mem_ack)
        begin
          nxt_cur.mem_req    = 1'b0;
          nxt_cur.pc         = patch_addr;
          nxt_cur.pipe_flush = 1'b1;
          nxt_cur.st         = ST_FLUSH;
        end
      ST_FLUSH:
      begin
        nxt_cur.resume    = 1'b1;
        nxt_cur.resume_pc = cur_ff.pc;
        nxt_cur.st        = ST_ANS;
      end
      ST_RSTP:
        if (cur_ff.rcnt == PRST_LAST)
        begin
          nxt_cur.prst_n = 1'b1;
          nxt_cur.st     = ST_ANS;
        end
        else
          nxt_cur.rcnt = cur_ff.rcnt + 10'h001;
      ST_ANS:
      begin
        nxt_cur.rsp_valid = 1'b1;
        nxt_cur.st = ST_IDLE;
      end
      default: nxt_cur.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge srst_n)
    if (!srst_n)
    begin
      cur_ff           <= '0;
      cur_ff.st        <= ST_IDLE;
      cur_ff.pc        <= PC_RST;
      cur_ff.sr        <= SR_RST;
      cur_ff.ssp       <= SSP_RST;
      cur_ff.prst_n    <= 1'b1;
    end
    else
      cur_ff <= nxt_cur;

  assign rsp_valid    = cur_ff.rsp_valid;
  assign rsp_data     = cur_ff.rsp_data;
  assign rsp_status   = cur_ff.rsp_status;
  assign mem_req      = cur_ff.mem_req;
  assign mem_we       = cur_ff.mem_we;
  assign mem_addr     = cur_ff.mem_addr;
  assign mem_fc       = cur_ff.mem_fc;
  assign mem_size     = cur_ff.mem_size;
  assign mem_wdata    = cur_ff.mem_wdata;
  assign pipe_flush   = cur_ff.pipe_flush;
  assign resume       = cur_ff.resume;
  assign resume_pc    = cur_ff.resume_pc;
  assign periph_rst_n = cur_ff.prst_n;
endmodule : bdc_unit

//--- bdc_unit_props.sv
// port-level assertion checker for the debug command unit
`timescale 1ns/1ps
module bdc_unit_props
  import bdc_pkg::*;
(
  input wire logic        clk,          // system clock
  input wire logic        rst_n,        // async reset, low active
  input wire logic        rsp_valid,    // answer pulse
  input wire logic [31:0] rsp_data,     // answer data
  input wire logic        mem_req,      // memory strobe
  input wire logic        mem_we,       // memory write
  input wire logic [31:0] mem_addr,     // memory address
  input wire logic [2:0]  mem_fc,       // address space code
  input wire logic [1:0]  mem_size,     // access size
  input wire logic [31:0] mem_wdata,    // write data
  input wire logic        mem_ack,      // memory done
  input wire logic [31:0] mem_rdata,    // read data
  input wire logic        pipe_flush,   // flush pulse
  input wire logic        resume,       // resume pulse
  input wire logic        periph_rst_n  // external reset line
);
  // counts low cycles of the reset line, cleared while it is high
  logic [10:0] lo_ff;
  logic [10:0] nxt_lo;
  always_comb nxt_lo = periph_rst_n ? 11'h0 : lo_ff + 11'h1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) lo_ff <= 11'h0;
    else lo_ff <= nxt_lo;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_long_rd;
    mem_req && mem_ack && !mem_we && mem_size == SZ_LONG;
  endsequence
  sequence s_flush_go;
    pipe_flush ##1 resume;
  endsequence

  a_rd_answer: assert property (s_long_rd |-> ##2
    (rsp_valid && rsp_data == $past(mem_rdata, 2)))
    else $error("read answer does not carry memory data");
  a_flush_resume: assert property (pipe_flush |-> s_flush_go)
    else $error("flush not followed by resume");
  a_resume_cause: assert property (resume |-> $past(pipe_flush))
    else $error("resume without prior flush");
  a_req_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_fc) &&
    $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  a_rst_width: assert property ($rose(periph_rst_n) |->
    lo_ff == 11'd512)
    else $error("reset pulse not 512 cycles");
  a_rst_bound: assert property (lo_ff <= 11'd512)
    else $error("reset pulse too long");
  a_rst_quiet: assert property (!periph_rst_n |->
    !rsp_valid && !mem_req && !resume)
    else $error("activity during reset pulse");
endmodule : bdc_unit_props

bind bdc_unit bdc_unit_props u_bdc_unit_props (
  .clk(clk), .rst_n(rst_n), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_fc(mem_fc), .mem_size(mem_size),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .pipe_flush(pipe_flush), .resume(resume),
  .periph_rst_n(periph_rst_n)
);

//--- bdc_mem_model.sv
// behavioural memory on the far side of the unit's memory port
`timescale 1ns/1ps
module bdc_mem_model (
  input  wire logic        clk,        // system clock
  input  wire logic [3:0]  dly,        // wait states before ack
  input  wire logic        mem_req,    // cycle strobe
  input  wire logic        mem_we,     // write
  input  wire logic [31:0] mem_addr,   // address
  input  wire logic [2:0]  mem_fc,     // space code
  input  wire logic [31:0] mem_wdata,  // write data
  output logic             mem_ack,    // cycle done
  output logic [31:0]      mem_rdata,  // read data
  output logic [31:0]      last_addr,  // address of last cycle
  output logic [31:0]      last_wdata, // data of last write
  output logic [2:0]       last_fc     // space code of last cycle
);
  logic [31:0] mem [logic [31:0]];
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    last_addr = 32'h0;
    last_wdata = 32'h0;
    last_fc = 3'h0;
    forever
    begin
      @(posedge clk);
      if (mem_req)
      begin
        repeat (dly) @(posedge clk);
        last_addr <= mem_addr;
        last_fc <= mem_fc;
        if (mem_we)
        begin
          mem[mem_addr] = mem_wdata;
          last_wdata <= mem_wdata;
        end
        // unwritten places answer with the inverted address
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
        mem_ack <= 1'b1;
        @(posedge clk);
        mem_ack <= 1'b0;
        // data released: never leave the last value standing
        mem_rdata <= ~mem_rdata;
        @(posedge clk);
      end
    end
  end
endmodule : bdc_mem_model

//--- test_bdc_unit.sv
// self-checking bench for the debug command unit
`timescale 1ns/1ps
module test_bdc_unit
  import bdc_pkg::*;
;
  typedef struct packed {
    logic [3:0]  op;
    logic [3:0]  sel;
    logic [31:0] data;
    logic [1:0]  st;
    logic [31:0] exp;
    logic        chk;
  } bdc_row_t;
  logic        clk, rst_n, cmd_valid, cmd_ready, rsp_valid, core_halted;
  logic        mem_req, mem_we, mem_ack, pipe_flush, resume, periph_rst_n;
  logic [3:0]  cmd_op, cmd_sel, dly;
  logic [1:0]  cmd_size, rsp_status, mem_size, r_st;
  logic [2:0]  mem_fc, last_fc;
  logic [31:0] cmd_data, rsp_data, patch_addr, mem_addr, mem_wdata;
  logic [31:0] mem_rdata, resume_pc, last_addr, last_wdata, r_data, go_pc;
  int          num_errors, compares, n_rsp, lo_cnt, n0, l0, acc;
  logic [31:0] a;
  bdc_row_t    rows [14] = '{
    '{CMD_WR_CORE, 4'h3, 32'h1111_2222, ST_OK, 32'h0, 1'b0},
    '{CMD_RD_CORE, 4'h3, 32'h0, ST_OK, 32'h1111_2222, 1'b1},
    '{CMD_WR_CORE, 4'hb, 32'h0000_0200, ST_OK, 32'h0, 1'b0},
    '{CMD_RD_CORE, 4'hb, 32'h0, ST_OK, 32'h0000_0200, 1'b1},
    '{CMD_WR_SYS, 4'h2, 32'h5, ST_OK, 32'h0, 1'b0},
    '{CMD_RD_SYS, 4'h2, 32'h0, ST_OK, 32'h5, 1'b1},
    '{CMD_WR_SYS, 4'h3, 32'h1, ST_OK, 32'h0, 1'b0},
    '{CMD_RD_SYS, 4'h3, 32'h0, ST_OK, 32'h1, 1'b1},
    '{CMD_RD_SYS, 4'h5, 32'h0, ST_OK, 32'h0000_1000, 1'b1},
    '{CMD_RD_SYS, 4'h1, 32'h0, ST_OK, 32'h0000_2700, 1'b1},
    '{CMD_WR_SYS, 4'h0, 32'h0000_0400, ST_OK, 32'h0, 1'b0},
    '{CMD_NOP, 4'h3, 32'hffff_ffff, ST_OK, 32'h0, 1'b0},
    '{CMD_RD_CORE, 4'h3, 32'h0, ST_OK, 32'h1111_2222, 1'b1},
    '{4'hf, 4'h0, 32'h0, ST_ILLEGAL, 32'h0, 1'b0}};

  bdc_unit u_bdc_unit (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sel(cmd_sel),
    .cmd_size(cmd_size), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_status(rsp_status),
    .core_halted(core_halted), .patch_addr(patch_addr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_fc(mem_fc), .mem_size(mem_size), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pipe_flush(pipe_flush),
    .resume(resume), .resume_pc(resume_pc), .periph_rst_n(periph_rst_n));
  bdc_mem_model u_bdc_mem_model (.clk(clk), .dly(dly), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_fc(mem_fc),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .last_addr(last_addr), .last_wdata(last_wdata), .last_fc(last_fc));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rsp_valid) n_rsp <= n_rsp + 1;
    if (rsp_valid) r_data <= rsp_data;
    if (rsp_valid) r_st <= rsp_status;
    if (!periph_rst_n) lo_cnt <= lo_cnt + 1;
    if (resume) go_pc <= resume_pc;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // holds the request until the edge at which ready is seen high
  task automatic push(input logic [3:0] op, sel, input logic [31:0] d);
    logic r;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_sel <= sel;
    cmd_data <= d;
    r = 1'b0;
    for (int i = 0; i < 2000 && !r; i++)
    begin
      #1 r = cmd_ready;
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    chk({31'h0, r}, 32'h1);
  endtask : push

  task automatic cmd(input logic [3:0] op, sel, input logic [31:0] d);
    n0 = n_rsp;
    push(op, sel, d);
    for (int i = 0; i < 2000 && n_rsp == n0; i++) @(posedge clk);
    chk(32'(n_rsp - n0), 32'h1);
  endtask : cmd

  initial
  begin
    {rst_n, cmd_valid, cmd_op, cmd_sel, cmd_data, dly} = '0;
    {num_errors, compares, n_rsp, lo_cnt} = '0;
    core_halted = 1'b1;
    cmd_size = SZ_LONG;
    patch_addr = 32'h0000_8000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i])
    begin
      cmd(rows[i].op, rows[i].sel, rows[i].data);
      chk({30'h0, r_st}, {30'h0, rows[i].st});
      if (rows[i].chk) chk(r_data, rows[i].exp);
    end
    $display("row tests done");
    cmd(CMD_DUMP, 4'h0, 32'h0);
    chk({30'h0, r_st}, {30'h0, ST_ILLEGAL});
    dly <= 4'h5;
    cmd(CMD_RD_MEM, 4'h0, 32'h0000_0100);
    chk(r_data, ~32'h0000_0100);
    chk({29'h0, last_fc}, 32'h5);
    cmd(CMD_DUMP, 4'h0, 32'h0);
    chk(r_data, ~32'h0000_0104);
    dly <= 4'h0;
    cmd(CMD_WR_MEM, 4'h0, 32'h0000_0200);
    chk({29'h0, last_fc}, 32'h1);
    a = last_addr;
    cmd(CMD_FILL, 4'h0, 32'h5a5a_0002);
    chk(last_addr, a + 32'h4);
    chk(last_wdata, 32'h5a5a_0002);
    cmd_size <= SZ_WORD;
    cmd(CMD_RD_MEM, 4'h0, 32'h0000_0300);
    cmd(CMD_DUMP, 4'h0, 32'h0);
    chk(last_addr, 32'h0000_0302);
    chk(r_data, ~32'h0000_0302);
    chk({30'h0, mem_size}, {30'h0, SZ_WORD});
    cmd_size <= SZ_LONG;
    $display("memory tests done");
    cmd(CMD_GO, 4'h0, 32'h0);
    chk(go_pc, 32'h0000_0400);
    cmd(CMD_CALL, 4'h0, 32'h0);
    chk(last_addr, 32'h0000_0ffc);
    chk(last_wdata, 32'h0000_0400);
    chk(go_pc, 32'h0000_8000);
    $display("resume tests done");
    l0 = lo_cnt;
    n0 = n_rsp;
    push(CMD_RST, 4'h0, 32'h0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= CMD_NOP;
    acc = 0;
    repeat (8)
    begin
      #1 acc += int'(cmd_ready);
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    chk(acc, 32'h4);
    for (int i = 0; i < 1500 && n_rsp < n0 + 5; i++) @(posedge clk);
    chk(32'(n_rsp - n0), 32'h5);
    chk(lo_cnt - l0, 32'd512);
    cmd(CMD_RD_CORE, 4'h3, 32'h0);
    chk(r_data, 32'h1111_2222);
    $display("peripheral reset tests done");
    core_halted <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(CMD_WR_CORE, 4'h3, 32'h0);
    chk({30'h0, r_st}, {30'h0, ST_NOT_HALT});
    core_halted <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(CMD_RD_CORE, 4'h3, 32'h0);
    chk(r_data, 32'h1111_2222);
    $display("halt tests done");
    push(CMD_RST, 4'h0, 32'h0);
    repeat (20) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, periph_rst_n}, 32'h1);
    chk({30'h0, rsp_valid, mem_req}, 32'h0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(CMD_RD_SYS, 4'h5, 32'h0);
    chk(r_data, 32'h0000_1000);
    $display("reset tests done");
    finish_test();
  end

  // all tests need under 4000 cycles
  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : test_bdc_unit
